// [shared/fps_pkg.sv]
/*
  Constants, types and timing figures for the fan PWM supervisor.
  Assumes a single 50 MHz system clock; the analog front end delivers
  comparator decisions and a duty command, not raw voltages.
*/
// Summary of operation
// - Drive duty follows the control voltage, 0% at span bottom to 100%.
// - The PWM period is the time base for every cycle counter except blanking, which counts ramp steps.
// - Starting the fan from off forces drive on for 32 PWM cycles.
// - A fan fault runs the diagnostic timer, then start-up, then shuts down.
// - Missing pulses count as a fault only outside shutdown and auto-shutdown.
// - A fan fault pulls the alarm low and latches shutdown until cleared.
// - Alarm is asserted while duty is 100%, unlatched, released below it.
// - Shutdown level enters shutdown with alarm off; release level exits.
// - Auto-shutdown stops the fan; restart needs level plus hysteresis.
// - Rotation pulses on the sense input are taken as proof of turning.
// - The fan drive output is active high.
// - No rotation pulse for 32 consecutive PWM cycles is a timeout.
// - The diagnostic timer drives the fan high for 3 PWM cycles.
// - Sense pulses caused by the drive turning on are blanked.
// - Entering shutdown clears timers and latched faults like power-up.
package fps_pkg;

  // ****************************************************************
  // Clock and time base
  // ****************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int PWM_RATE_HZ = 30;
  localparam int DUTY_W = 8;
  localparam int RAMP_STEPS = 2 ** DUTY_W;
  // Period rounds down so the PWM never runs slower than nominal
  localparam int STEP_CYCLES = CLK_HZ / (PWM_RATE_HZ * RAMP_STEPS);

  // ****************************************************************
  // Supervision counts, in PWM cycles; blanking in ramp steps
  // ****************************************************************
  localparam int STARTUP_PWM = 32;
  localparam int MISS_PWM = 32;
  localparam int DIAG_PWM = 3;
  localparam int CNT_W = 6;
  localparam int BLANK_STEPS = 4;

  // Comparator decisions from the analog front end
  typedef struct packed {
    logic shdn_lo; // Control voltage at or below shutdown level
    logic rel_hi;  // Control voltage at or above release level
    logic as_lo;   // At or below auto-shutdown level
    logic as_hi;   // Above auto-shutdown level plus hysteresis
    logic full_hi; // At or above the full duty level
  } fps_cmp_s;

  // Supervisor states, one-hot
  typedef enum logic [6:0] {
    ST_OFF   = 7'h01,
    ST_AUTO  = 7'h02,
    ST_START = 7'h04,
    ST_RETRY = 7'h08,
    ST_RUN   = 7'h10,
    ST_DIAG  = 7'h20,
    ST_FAULT = 7'h40
  } fps_state_e;

endpackage

// [test/fps_fan_model.sv]
/*
  Behavioural brushless fan behind a low-side switch, as seen by the
  supervisor: rotation pulses while spinning, plus a turn-on glitch.
  Assumes the bench steps spin_en_i to stall or free the rotor.
*/
module fps_fan_model (
  input wire logic mclk_i,    // System clock
  input wire logic rst_b_i,   // Async reset, active low
  input wire logic drive_i,   // Fan drive from the block
  input wire logic spin_en_i, // Rotor free to turn
  output logic rot_pulse_o    // Conditioned rotation pulse
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Rotor and sense model
  // ****************************************************************
  logic [10:0] idle;
  logic [6:0] ph;
  logic drive_q;
  logic [1:0] glitch;

  // Rotor coasts about four periods after drive stops, then stalls
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle <= 11'h7ff;
      ph <= 7'h00;
      drive_q <= 1'b0;
      glitch <= 2'h0;
    end else begin
      drive_q <= drive_i;
      if (drive_i) begin // High switches the fan on
        idle <= 11'h000;
      end else if (idle != 11'h7ff) begin
        idle <= idle + 11'h001;
      end
      ph <= ph + 7'h01;
      // Current step on switch-on looks like a pulse
      if (drive_i && !drive_q) begin
        glitch <= 2'h2;
      end else if (glitch != 2'h0) begin
        glitch <= glitch - 2'h1;
      end
    end
  end

  // Commutation pulses only while the rotor really turns
  assign rot_pulse_o = (spin_en_i && idle < 11'h400 && ph < 7'h04) ||
                       (glitch != 2'h0);
endmodule

// [test/tb_fan_pwm_supervisor.sv]
/*
  Self-checking bench for the fan PWM supervisor with a fan model.
  Assumes a shortened ramp step so every long count runs in full.
*/
module tb_fan_pwm_supervisor;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int STEP = 1;
  localparam int PER = 256 * STEP;

  logic mclk_i, rst_b_i, rot_pulse_i, spin_en;
  logic fan_drive_out_o, alarm_od_o, alarm_oe_o, pwm_tick_o;
  fps_pkg::fps_cmp_s cmp_i;
  logic [fps_pkg::DUTY_W-1:0] duty_cmd_i;
  wire fault_b;
  int num_errors, compares, hi, al;

  // Open-drain alarm pin with its pull-up
  assign fault_b = alarm_oe_o ? alarm_od_o : 1'b1;

  fps_top #(.STEP_CYCLES(STEP)) dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .cmp_i(cmp_i),
    .duty_cmd_i(duty_cmd_i), .rot_pulse_i(rot_pulse_i),
    .fan_drive_out_o(fan_drive_out_o), .alarm_od_o(alarm_od_o),
    .alarm_oe_o(alarm_oe_o), .pwm_tick_o(pwm_tick_o));

  fps_fan_model fan (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .drive_i(fan_drive_out_o), .spin_en_i(spin_en),
    .rot_pulse_o(rot_pulse_i));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Sampling on the falling edge keeps clear of register updates
  task wait_tick(input int n);
    repeat (n) begin
      do @(negedge mclk_i); while (pwm_tick_o !== 1'b1);
    end
  endtask

  // Counts drive-high and alarm-low samples over n whole periods
  task run_ticks(input int n, output int h, output int a);
    int k;
    h = 0;
    a = 0;
    k = 0;
    while (k < n) begin
      @(negedge mclk_i);
      if (fan_drive_out_o === 1'b1) h++;
      if (fault_b === 1'b0) a++;
      if (pwm_tick_o === 1'b1) k++;
    end
  endtask

  task final_report;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_startup;
    check(fan_drive_out_o, 0);
    check(fault_b, 1);
    rst_b_i <= 1'b1;
    repeat (2) @(negedge mclk_i);
    check(fan_drive_out_o, 1);
    wait_tick(1);
    run_ticks(30, hi, al);
    check(hi, 30 * PER);
    wait_tick(3);
  endtask

  task t_duty;
    logic [7:0] d[3];
    d = '{8'h00, 8'h01, 8'hA5};
    foreach (d[i]) begin
      @(posedge mclk_i);
      duty_cmd_i <= d[i];
      wait_tick(2);
      run_ticks(1, hi, al);
      check(hi, d[i] * STEP);
      check(al, 0);
    end
  endtask

  // Full drive raises the alarm without latching it
  task t_full;
    @(posedge mclk_i);
    cmp_i.full_hi <= 1'b1;
    wait_tick(3);
    run_ticks(1, hi, al);
    check(hi, PER);
    check(al, PER);
    @(posedge mclk_i);
    cmp_i.full_hi <= 1'b0;
    wait_tick(3);
    run_ticks(1, hi, al);
    check(al, 0);
    check(hi, 8'hA5 * STEP);
  endtask

  // Stalled rotor with only switch-on glitches must end in a fault
  task t_fault;
    int n, full;
    n = 0;
    full = 0;
    @(posedge mclk_i);
    duty_cmd_i <= 8'h80;
    spin_en <= 1'b0;
    do begin
      run_ticks(1, hi, al);
      n++;
      if (hi == PER) full++;
    end while (al == 0 && n < 80);
    check(n >= 65 && n <= 70, 1);
    check(full >= 33, 1);
    @(posedge mclk_i);
    spin_en <= 1'b1;
    wait_tick(1);
    run_ticks(4, hi, al);
    check(hi, 0);
    check(al, 4 * PER);
    check(alarm_od_o, 0);
  endtask

  // Shutdown clears the latched fault and restarts with full drive
  task t_shutdown;
    @(posedge mclk_i);
    cmp_i.shdn_lo <= 1'b1;
    cmp_i.rel_hi <= 1'b0;
    cmp_i.full_hi <= 1'b1;
    wait_tick(3);
    run_ticks(2, hi, al);
    check(hi, 0);
    check(al, 0);
    @(posedge mclk_i);
    cmp_i.shdn_lo <= 1'b0;
    cmp_i.rel_hi <= 1'b1;
    cmp_i.full_hi <= 1'b0;
    wait_tick(3);
    run_ticks(8, hi, al);
    check(hi, 8 * PER);
    check(al, 0);
  endtask

  // Stopped rotor in auto-shutdown is not a fault
  task t_auto;
    @(posedge mclk_i);
    cmp_i.as_lo <= 1'b1;
    cmp_i.as_hi <= 1'b0;
    cmp_i.full_hi <= 1'b1;
    spin_en <= 1'b0;
    wait_tick(3);
    run_ticks(36, hi, al);
    check(hi, 0);
    check(al, 0);
    @(posedge mclk_i);
    cmp_i.as_lo <= 1'b0;
    cmp_i.full_hi <= 1'b0;
    wait_tick(3);
    run_ticks(3, hi, al);
    check(hi, 0);
    @(posedge mclk_i);
    cmp_i.as_hi <= 1'b1;
    spin_en <= 1'b1;
    wait_tick(3);
    run_ticks(4, hi, al);
    check(hi, 4 * PER);
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // Bound set well above the roughly 50k cycles the sequence takes
  initial begin
    #(75_000 * 20);
    num_errors++;
    final_report;
  end

  initial begin
    num_errors = 0;
    compares = 0;
    rst_b_i = 1'b0;
    spin_en = 1'b1;
    duty_cmd_i = 8'h40;
    cmp_i = '{shdn_lo: 1'b0, rel_hi: 1'b1, as_lo: 1'b0,
              as_hi: 1'b1, full_hi: 1'b0};
    repeat (4) @(posedge mclk_i);
    t_startup;
    t_duty;
    t_full;
    t_fault;
    t_shutdown;
    t_auto;
    final_report;
  end
endmodule

// [verilog/fps_top.sv]
/*
  Fan PWM supervisor: duty generation, start-up and diagnostic timers,
  missing-pulse detection, fault latch and alarm.
  Assumes comparator decisions and the rotation pulse arrive
  asynchronously, and the duty command comes from logic on mclk_i.
*/
module fps_top #(
  parameter int STEP_CYCLES = fps_pkg::STEP_CYCLES
) (
  input wire logic mclk_i,                    // 50 MHz clock
  input wire logic rst_b_i,                   // Async reset, active low
  input wire fps_pkg::fps_cmp_s cmp_i,        // Async comparator decisions
  input wire logic [fps_pkg::DUTY_W-1:0] duty_cmd_i, // Duty command
  input wire logic rot_pulse_i,               // Async rotation pulse
  output logic fan_drive_out_o,               // Fan drive, active high
  output logic alarm_od_o,                    // Alarm pin data, always low
  output logic alarm_oe_o,                    // High pulls the alarm low
  output logic pwm_tick_o                     // One pulse per PWM period
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  fps_pkg::fps_cmp_s cmp_m, cmp_s;
  logic rot_m, rot_s, rot_d;

  // Two flops per asynchronous input before any use
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmp_m <= '0;
      cmp_s <= '0;
      rot_m <= 1'b0;
      rot_s <= 1'b0;
      rot_d <= 1'b0;
    end else begin
      cmp_m <= cmp_i;
      cmp_s <= cmp_m;
      rot_m <= rot_pulse_i;
      rot_s <= rot_m;
      rot_d <= rot_s;
    end
  end

  // ****************************************************************
  // Time base: step divider and ramp
  // ****************************************************************
  localparam int SW = $clog2(STEP_CYCLES + 1);
  logic [SW-1:0] step_cnt, next_step_cnt;
  logic [fps_pkg::DUTY_W-1:0] ramp, next_ramp;
  logic step_en, tick;

  // Ramp advances once per step; wrap marks the PWM boundary
  always_comb begin
    step_en = (step_cnt == SW'(STEP_CYCLES - 1));
    next_step_cnt = step_en ? '0 : step_cnt + SW'(1);
    next_ramp = step_en ? ramp + fps_pkg::DUTY_W'(1) : ramp;
    tick = step_en && (ramp == {fps_pkg::DUTY_W{1'b1}});
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_cnt <= '0;
      ramp <= '0;
    end else begin
      step_cnt <= next_step_cnt;
      ramp <= next_ramp;
    end
  end

  // ****************************************************************
  // Mode flags with hysteresis
  // ****************************************************************
  logic shdn_mode, next_shdn_mode, as_mode, next_as_mode;

  // Updated only at the PWM boundary; set wins over release
  always_comb begin
    next_shdn_mode = shdn_mode;
    next_as_mode = as_mode;
    if (tick) begin
      if (cmp_s.shdn_lo) begin
        next_shdn_mode = 1'b1;
      end else if (cmp_s.rel_hi) begin
        next_shdn_mode = 1'b0;
      end
      if (cmp_s.as_lo) begin
        next_as_mode = 1'b1;
      end else if (cmp_s.as_hi) begin
        next_as_mode = 1'b0;
      end
    end
  end

  // Power-up counts as a start from off, so both flags start clear
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shdn_mode <= 1'b0;
      as_mode <= 1'b0;
    end else begin
      shdn_mode <= next_shdn_mode;
      as_mode <= next_as_mode;
    end
  end

  // ****************************************************************
  // Rotation sense with blanking
  // ****************************************************************
  localparam int BW = $clog2(fps_pkg::BLANK_STEPS + 1);
  logic [BW-1:0] blank_cnt, next_blank_cnt;
  logic seen, next_seen, rot_edge, seen_now, drive_rise;
  logic next_drive;

  // Drive turn-on transients would fake rotation, so mask them
  always_comb begin
    drive_rise = next_drive && !fan_drive_out_o;
    next_blank_cnt = blank_cnt;
    if (drive_rise) begin
      next_blank_cnt = BW'(fps_pkg::BLANK_STEPS);
    end else if (step_en && blank_cnt != '0) begin
      next_blank_cnt = blank_cnt - BW'(1);
    end
    rot_edge = rot_s && !rot_d && (blank_cnt == '0);
    // Pulse in the boundary cycle still counts for the ending period
    seen_now = seen || rot_edge;
    next_seen = tick ? 1'b0 : seen_now;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      blank_cnt <= '0;
      seen <= 1'b0;
    end else begin
      blank_cnt <= next_blank_cnt;
      seen <= next_seen;
    end
  end

  // ****************************************************************
  // Supervisor state machine
  // ****************************************************************
  localparam logic [fps_pkg::CNT_W-1:0] START_LAST =
    fps_pkg::CNT_W'(fps_pkg::STARTUP_PWM - 1);
  localparam logic [fps_pkg::CNT_W-1:0] MISS_LAST =
    fps_pkg::CNT_W'(fps_pkg::MISS_PWM - 1);
  localparam logic [fps_pkg::CNT_W-1:0] DIAG_LAST =
    fps_pkg::CNT_W'(fps_pkg::DIAG_PWM - 1);

  fps_pkg::fps_state_e state, next_state;
  logic [fps_pkg::CNT_W-1:0] cnt, next_cnt;
  logic cnt_inc, got, next_got, got_now;

  // Priority shutdown, fault hold, auto-shutdown, then sequencing, per boundary
  always_comb begin
    next_state = state;
    cnt_inc = 1'b0;
    got_now = got || seen_now;
    if (tick) begin
      if (next_shdn_mode) begin
        next_state = fps_pkg::ST_OFF;
      end else if (state == fps_pkg::ST_FAULT) begin
        next_state = fps_pkg::ST_FAULT; // Latched until shutdown
      end else if (next_as_mode) begin
        next_state = fps_pkg::ST_AUTO;
      end else begin
        case (state)
          fps_pkg::ST_OFF, fps_pkg::ST_AUTO: begin
            next_state = fps_pkg::ST_START; // Restart from off
          end
          // Timers always run full length, pulses only pick the exit
          fps_pkg::ST_START, fps_pkg::ST_RETRY: begin
            cnt_inc = 1'b1;
            if (cnt == START_LAST) begin
              next_state = got_now ? fps_pkg::ST_RUN :
                (state == fps_pkg::ST_START) ? fps_pkg::ST_RETRY :
                fps_pkg::ST_FAULT;
            end
          end
          fps_pkg::ST_RUN: begin
            cnt_inc = !seen_now;
            if (!seen_now && cnt == MISS_LAST) begin
              next_state = fps_pkg::ST_DIAG;
            end
          end
          fps_pkg::ST_DIAG: begin
            cnt_inc = 1'b1;
            if (cnt == DIAG_LAST) begin
              next_state = got_now ? fps_pkg::ST_RUN : fps_pkg::ST_RETRY;
            end
          end
          default: begin
            next_state = fps_pkg::ST_OFF;
          end
        endcase
      end
    end
    // Any state change, or a pulse while running, restarts the count
    if (next_state != state || (tick && seen_now && !cnt_inc)) begin
      next_cnt = '0;
    end else if (cnt_inc) begin
      next_cnt = cnt + fps_pkg::CNT_W'(1);
    end else begin
      next_cnt = cnt;
    end
    // A pulse anywhere in a timer is kept until the timer ends
    next_got = (next_state != state) ? 1'b0 : (tick ? got_now : got);
  end

  // Reset lands in start-up: power-up is a start from off
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= fps_pkg::ST_START;
      cnt <= '0;
      got <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      got <= next_got;
    end
  end

  // ****************************************************************
  // Drive and alarm outputs
  // ****************************************************************
  logic full_duty, next_alarm, alarm, tick_q;

  // Full drive in timers, ramp compare in run, off elsewhere
  always_comb begin
    full_duty = cmp_s.full_hi;
    case (state)
      fps_pkg::ST_START, fps_pkg::ST_RETRY, fps_pkg::ST_DIAG: begin
        next_drive = 1'b1;
      end
      fps_pkg::ST_RUN: begin
        next_drive = full_duty || (ramp < duty_cmd_i);
      end
      default: begin
        next_drive = 1'b0;
      end
    endcase
    // Fault latches the alarm; full duty asserts it only while true
    case (state)
      fps_pkg::ST_FAULT: next_alarm = 1'b1;
      fps_pkg::ST_START, fps_pkg::ST_RETRY, fps_pkg::ST_RUN,
      fps_pkg::ST_DIAG: next_alarm = full_duty;
      default: next_alarm = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fan_drive_out_o <= 1'b0;
      alarm <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      fan_drive_out_o <= next_drive; // High turns the switch on
      alarm <= next_alarm;
      tick_q <= tick;
    end
  end

  // Open-drain alarm: only ever pulls low
  assign alarm_od_o = 1'b0;
  assign alarm_oe_o = alarm;
  assign pwm_tick_o = tick_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_diag_expire;
    tick && state == fps_pkg::ST_DIAG && cnt == DIAG_LAST && !got_now;
  endsequence

  property p_shdn_first;
    tick && next_shdn_mode |=> state == fps_pkg::ST_OFF;
  endproperty
  a_shdn_first: assert property (p_shdn_first)
    else $error("shutdown not entered at boundary");

  property p_fault_latch;
    state == fps_pkg::ST_FAULT && !next_shdn_mode
      |=> state == fps_pkg::ST_FAULT;
  endproperty
  a_fault_latch: assert property (p_fault_latch)
    else $error("fault state left without shutdown");

  property p_fault_alarm;
    state == fps_pkg::ST_FAULT [*2] |-> alarm_oe_o && !fan_drive_out_o;
  endproperty
  a_fault_alarm: assert property (p_fault_alarm)
    else $error("fault without alarm or with drive");

  property p_quiet_modes;
    (state == fps_pkg::ST_OFF || state == fps_pkg::ST_AUTO) [*2]
      |-> !alarm_oe_o && !fan_drive_out_o;
  endproperty
  a_quiet_modes: assert property (p_quiet_modes)
    else $error("alarm or drive active while off");

  property p_timer_drive;
    (rst_b_i && (state == fps_pkg::ST_START || state == fps_pkg::ST_DIAG))
      [*2] |-> fan_drive_out_o;
  endproperty
  a_timer_drive: assert property (p_timer_drive)
    else $error("drive low during a forced-on timer");

  property p_miss_timeout;
    tick && state == fps_pkg::ST_RUN && cnt == MISS_LAST && !seen_now
      && !next_shdn_mode && !next_as_mode |=> state == fps_pkg::ST_DIAG;
  endproperty
  a_miss_timeout: assert property (p_miss_timeout)
    else $error("missing pulse timeout not taken");

  property p_diag_retry;
    s_diag_expire ##0 (!next_shdn_mode && !next_as_mode)
      |=> state == fps_pkg::ST_RETRY ##1 fan_drive_out_o;
  endproperty
  a_diag_retry: assert property (p_diag_retry)
    else $error("diagnostic expiry did not retry start-up");

  property p_blank;
    blank_cnt != '0 |-> !rot_edge;
  endproperty
  a_blank: assert property (p_blank)
    else $error("rotation edge accepted while blanked");

  property p_overtemp;
    state == fps_pkg::ST_RUN && full_duty |=> alarm_oe_o;
  endproperty
  a_overtemp: assert property (p_overtemp)
    else $error("full duty without alarm");

  property p_count_bound;
    state == fps_pkg::ST_DIAG |-> cnt <= DIAG_LAST;
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("diagnostic count overran");

endmodule
